// ### logic/down_counter_timer.sv
// 8-bit down counter behind a 7-bit prescaler, wishbone register slave
// assumes ref_clk at 100 MHz; timer pin is asynchronous and is synchronised
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Contract
// - counter decrements on each rising edge of the selected prescaler tap
// - counter decrementing to zero sets the zero flag
// - interrupt request while zero flag and its enable are both one
// - prescaler input is core clock over 12 or the pin, on rising edges
// - tap select gives divide 1 to 128; divide 2^n uses bit n-1
// - run bit low forces prescaler to 7fh and stops prescaler and counter
// - with run bit high software may write any prescaler value
// - direction and data bits choose event, gated or output mode
// - gated mode counts core over 12 only while pin is high
// - event mode counts rising edges of the pin
// - output mode: data passes to pin while zero flag high, else held
// - writing 00h to count or one to control bit 7 sets zero flag
// - reset loads count ffh, prescaler 7fh, control cleared
// - a count write beats a coincident decrement to zero; no flag set
// - count and prescaler read accurately; prescaler bit 7 reads zero
// - the interrupt request also wakes the processor from wait
module down_counter_timer #(
    parameter int unsigned CORE_DIV = timer_pkg::CORE_DIV
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [timer_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timerPinIn,
    output logic timerPinOut,
    output logic timerPinOe,
    output logic irq,
    output logic wakeReq
);
    logic [7:0] count_q;
    logic [6:0] prescale_q;
    logic [6:0] prescale_d;
    logic [7:0] count_d;
    logic zeroFlag_q;
    logic irqEnable_q;
    logic pinDir_q;
    logic pinData_q;
    logic run_q;
    logic [2:0] tapSel_q;
    logic [timer_pkg::EVT_W-1:0] evtStatus_q;
    logic [timer_pkg::EVT_W-1:0] evtEnable_q;
    logic coreTick;
    logic pinLevel;
    logic pinRise;
    timer_pkg::mode_e mode;

    tick_divider #(
        .DIV(CORE_DIV)
    ) u_core_div (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tick(coreTick)
    );

    // pin feeds logic only after two flops
    pin_sync u_pin_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pinAsync(timerPinIn),
        .level(pinLevel),
        .rise(pinRise)
    );

    // bus decode; writes land on the edge that sees ack high
    wire busReq = cyc_i & stb_i;
    wire wrEn = busReq & ack_o & we_i & sel_i[0];
    wire [7:0] wrByte = dat_i[7:0];
    wire hitPs = (adr_i == timer_pkg::ADR_PRESCALE);
    wire hitCnt = (adr_i == timer_pkg::ADR_COUNT);
    wire hitCtl = (adr_i == timer_pkg::ADR_CONTROL);
    wire hitSts = (adr_i == timer_pkg::ADR_EVT_STATUS);
    wire hitClr = (adr_i == timer_pkg::ADR_EVT_CLEAR);
    wire hitEn = (adr_i == timer_pkg::ADR_EVT_ENABLE);
    wire psWr = wrEn & hitPs & run_q;
    wire cntWr = wrEn & hitCnt;
    wire ctlWr = wrEn & hitCtl;
    wire clrWr = wrEn & hitClr;
    wire enWr = wrEn & hitEn;

    // mode from direction and data bits
    assign mode = pinDir_q ? timer_pkg::MODE_OUTPUT :
                  (pinData_q ? timer_pkg::MODE_GATED : timer_pkg::MODE_EVENT);

    logic srcTick;
    always_comb
    begin
        case (mode)
            timer_pkg::MODE_EVENT: srcTick = pinRise;
            timer_pkg::MODE_GATED: srcTick = coreTick & pinLevel;
            timer_pkg::MODE_OUTPUT: srcTick = coreTick;
            default: srcTick = 1'b0;
        endcase
    end

    // a tap bit rises when the down count borrows through it
    wire psTick = run_q & srcTick;
    wire [6:0] psDec = prescale_q - 7'h01;
    wire [2:0] tapBit = tapSel_q - 3'h1;
    wire tapEdge = ~prescale_q[tapBit] & psDec[tapBit];
    wire tapRise = psTick & ((tapSel_q == 3'h0) | tapEdge);
    wire cntStep = run_q & tapRise;
    wire hwZero = cntStep & (count_q == 8'h01) & ~cntWr;

    always_comb
    begin
        if (!run_q)
            prescale_d = timer_pkg::RST_PRESCALE;
        else if (psWr)
            prescale_d = wrByte[6:0];
        else if (psTick)
            prescale_d = psDec;
        else
            prescale_d = prescale_q;
    end

    always_comb
    begin
        if (cntWr)
            count_d = wrByte;
        else if (cntStep)
            count_d = count_q - 8'h01;
        else
            count_d = count_q;
    end

    // set beats a software clear in the same cycle
    wire zeroSet = hwZero | (cntWr & (wrByte == 8'h00))
                 | (ctlWr & wrByte[timer_pkg::BIT_ZERO]);
    wire zeroClr = ctlWr & ~wrByte[timer_pkg::BIT_ZERO];
    wire zeroFlag_d = zeroSet | (zeroFlag_q & ~zeroClr);

    wire [timer_pkg::EVT_W-1:0] evtSet = {pinRise, hwZero};
    wire [timer_pkg::EVT_W-1:0] evtClr = clrWr ? wrByte[timer_pkg::EVT_W-1:0] : '0;
    wire [timer_pkg::EVT_W-1:0] evtStatus_d = evtSet | (evtStatus_q & ~evtClr);
    wire irq_d = (zeroFlag_q & irqEnable_q) | (|(evtStatus_q & evtEnable_q));

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= timer_pkg::RST_COUNT;
            prescale_q <= timer_pkg::RST_PRESCALE;
        end
        else
        begin
            count_q <= count_d;
            prescale_q <= prescale_d;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            zeroFlag_q <= timer_pkg::RST_CONTROL[timer_pkg::BIT_ZERO];
            irqEnable_q <= timer_pkg::RST_CONTROL[timer_pkg::BIT_IRQ_EN];
            pinDir_q <= timer_pkg::RST_CONTROL[timer_pkg::BIT_DIR];
            pinData_q <= timer_pkg::RST_CONTROL[timer_pkg::BIT_DATA];
            run_q <= timer_pkg::RST_CONTROL[timer_pkg::BIT_RUN];
            tapSel_q <= timer_pkg::RST_CONTROL[timer_pkg::TAP_LSB+:3];
        end
        else
        begin
            zeroFlag_q <= zeroFlag_d;
            if (ctlWr)
            begin
                irqEnable_q <= wrByte[timer_pkg::BIT_IRQ_EN];
                pinDir_q <= wrByte[timer_pkg::BIT_DIR];
                pinData_q <= wrByte[timer_pkg::BIT_DATA];
                run_q <= wrByte[timer_pkg::BIT_RUN];
                tapSel_q <= wrByte[timer_pkg::TAP_LSB+:3];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            evtStatus_q <= '0;
            evtEnable_q <= '0;
            irq <= 1'b0;
            wakeReq <= 1'b0;
        end
        else
        begin
            evtStatus_q <= evtStatus_d;
            if (enWr)
                evtEnable_q <= wrByte[timer_pkg::EVT_W-1:0];
            irq <= irq_d;
            wakeReq <= irq_d;
        end
    end

    // pin latch: transparent while the flag is high, held otherwise
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timerPinOut <= 1'b0;
            timerPinOe <= 1'b0;
        end
        else
        begin
            if (zeroFlag_q)
                timerPinOut <= pinData_q;
            timerPinOe <= pinDir_q;
        end
    end

    // read data from live state; clear register reads zero
    wire [7:0] ctlRead = {zeroFlag_q, irqEnable_q, pinDir_q, pinData_q, run_q, tapSel_q};
    wire [7:0] rdByte = hitPs ? {1'b0, prescale_q} :
                        hitCnt ? count_q :
                        hitCtl ? ctlRead :
                        hitSts ? 8'(evtStatus_q) :
                        hitEn ? 8'(evtEnable_q) : 8'h00;

    // one wait state: ack follows request by one cycle, then drops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= busReq & ~ack_o;
            if (busReq & ~ack_o)
                dat_o <= {24'h00_0000, rdByte};
        end
    end

    // cycles since the last core tick; seeded so the first gap after reset checks too
    logic [7:0] tickGap_q;
    // low prescaler bits that must all be zero for the selected tap to borrow
    wire [7:0] tapSpan = 8'h01 << tapSel_q;
    wire [6:0] tapMask = 7'(tapSpan - 8'h01);
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            tickGap_q <= 8'hff;
        else if (coreTick)
            tickGap_q <= 8'h00;
        else
            tickGap_q <= tickGap_q + 8'h01;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_ack_single_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held more than one cycle");
    a_decrement_step: assert property (cntStep && !cntWr
        |=> count_q == $past(count_q) - 8'h01)
        else $error("counter did not step down by one");
    a_zero_sets_flag: assert property (hwZero |=> zeroFlag_q && count_q == 8'h00)
        else $error("zero reached without flag");
    a_irq_follows_flag: assert property (zeroFlag_q && irqEnable_q |=> irq && wakeReq)
        else $error("irq missing with flag and enable");
    a_irq_needs_enable: assert property (!irqEnable_q && !(|(evtStatus_q & evtEnable_q))
        |=> !irq)
        else $error("irq without enable");
    a_stop_preset: assert property (!run_q |=> prescale_q == 7'h7f)
        else $error("stopped prescaler not at 7f");
    a_stop_holds_count: assert property (!run_q && !cntWr |=> $stable(count_q))
        else $error("counter moved while stopped");
    a_gated_stall: assert property (mode == timer_pkg::MODE_GATED && !pinLevel
        && run_q && !psWr |=> $stable(prescale_q))
        else $error("gated prescaler moved with pin low");
    a_write_wins: assert property (cntWr
        |=> count_q == $past(wrByte) && !$past(hwZero))
        else $error("count write lost");
    a_zero_write_flag: assert property (cntWr && wrByte == 8'h00 |=> zeroFlag_q)
        else $error("writing zero did not set flag");
    a_out_transparent: assert property (zeroFlag_q |=> timerPinOut == $past(pinData_q))
        else $error("pin not following data while flag high");
    a_out_held: assert property (!zeroFlag_q |=> $stable(timerPinOut))
        else $error("pin changed while flag low");
    a_prescale_top_zero: assert property (ack_o && hitPs |-> dat_o[7] == 1'b0)
        else $error("prescaler bit 7 read as one");
    a_ps_step_down: assert property (psTick && !psWr
        |=> prescale_q == $past(prescale_q) - 7'h01)
        else $error("prescaler did not step down");
    a_ps_write_load: assert property (psWr
        |=> {1'b0, prescale_q} == ($past(wrByte) & 8'h7f))
        else $error("prescaler write lost while running");
    a_tap_div1: assert property (tapSel_q == 3'h0 && psTick && !cntWr
        |=> count_q == $past(count_q) - 8'h01)
        else $error("divide by one missed a step");
    a_tap_borrow: assert property (tapSel_q != 3'h0 && psTick && !cntWr
        && (prescale_q & tapMask) == 7'h00 |=> count_q == $past(count_q) - 8'h01)
        else $error("tap borrow did not step counter");
    a_tap_hold: assert property (tapSel_q != 3'h0 && psTick && !cntWr
        && (prescale_q & tapMask) != 7'h00 |=> $stable(count_q))
        else $error("counter stepped without tap borrow");
    a_count_idle: assert property (!psTick && !cntWr |=> $stable(count_q))
        else $error("counter moved without prescaler tick");
    a_flag_needs_set: assert property (!zeroFlag_q && !hwZero && !cntWr && !ctlWr
        |=> !zeroFlag_q)
        else $error("zero flag rose without cause");
    a_ctl_sets_flag: assert property (ctlWr && wrByte[timer_pkg::BIT_ZERO]
        |=> zeroFlag_q)
        else $error("control bit 7 did not set flag");
    a_collide_no_flag: assert property (cntWr && wrByte != 8'h00 && !zeroFlag_q
        |=> !zeroFlag_q)
        else $error("nonzero count write set the flag");
    a_oe_follows_dir: assert property (1'b1 |=> timerPinOe == $past(pinDir_q))
        else $error("pin enable not following direction");
    a_event_rise_step: assert property (mode == timer_pkg::MODE_EVENT && pinRise
        && run_q && !psWr |=> prescale_q == $past(prescale_q) - 7'h01)
        else $error("pin edge did not step prescaler");
    a_event_hold: assert property (mode == timer_pkg::MODE_EVENT && !pinRise
        && run_q && !psWr |=> $stable(prescale_q))
        else $error("prescaler moved without pin edge");
    a_gated_runs: assert property (mode == timer_pkg::MODE_GATED && pinLevel
        && coreTick && run_q && !psWr |=> prescale_q == $past(prescale_q) - 7'h01)
        else $error("gated prescaler missed a core tick");
    a_output_core_only: assert property (mode == timer_pkg::MODE_OUTPUT && !coreTick
        && run_q && !psWr |=> $stable(prescale_q))
        else $error("output mode prescaler moved off tick");
    a_core_tick_period: assert property (coreTick |-> tickGap_q == 8'(CORE_DIV - 1))
        else $error("core tick period wrong");
    a_wake_follows_irq: assert property (1'b1 |-> wakeReq == irq)
        else $error("wake request differs from irq");
    a_count_read: assert property (ack_o && hitCnt && !we_i
        |-> dat_o[7:0] == $past(count_q))
        else $error("count read not accurate");
    a_ps_read: assert property (ack_o && hitPs && !we_i
        |-> dat_o[7:0] == {1'b0, $past(prescale_q)})
        else $error("prescaler read not accurate");

    c_zero_reached: cover property (hwZero && irqEnable_q ##1 irq);
    c_gated_step: cover property (mode == timer_pkg::MODE_GATED && cntStep);
    c_event_mode_step: cover property (mode == timer_pkg::MODE_EVENT && cntStep);
    c_write_collides: cover property (cntWr && cntStep && count_q == 8'h01);
    c_output_pin_high: cover property (pinDir_q && zeroFlag_q ##1 timerPinOut);
endmodule

// ### include/timer_pkg.sv
// constants for the down counter timer with prescaler
// assumes a 100 MHz core clock and a classic wishbone register slave
package timer_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CORE_DIV = 12;
    localparam int unsigned ADR_W = 10;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRESCALE = 8'hd2;
    localparam logic [7:0] IDX_COUNT = 8'hd3;
    localparam logic [7:0] IDX_CONTROL = 8'hd4;
    localparam logic [7:0] IDX_EVT_STATUS = 8'hd5;
    localparam logic [7:0] IDX_EVT_CLEAR = 8'hd6;
    localparam logic [7:0] IDX_EVT_ENABLE = 8'hd7;
    localparam logic [ADR_W-1:0] ADR_PRESCALE = {IDX_PRESCALE, 2'b00};
    localparam logic [ADR_W-1:0] ADR_COUNT = {IDX_COUNT, 2'b00};
    localparam logic [ADR_W-1:0] ADR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [ADR_W-1:0] ADR_EVT_STATUS = {IDX_EVT_STATUS, 2'b00};
    localparam logic [ADR_W-1:0] ADR_EVT_CLEAR = {IDX_EVT_CLEAR, 2'b00};
    localparam logic [ADR_W-1:0] ADR_EVT_ENABLE = {IDX_EVT_ENABLE, 2'b00};
    // control/status fields
    localparam int unsigned BIT_ZERO = 7;
    localparam int unsigned BIT_IRQ_EN = 6;
    localparam int unsigned BIT_DIR = 5;
    localparam int unsigned BIT_DATA = 4;
    localparam int unsigned BIT_RUN = 3;
    localparam int unsigned TAP_LSB = 0;
    // event status bits
    localparam int unsigned EVT_W = 2;
    localparam int unsigned EVT_ZERO = 0;
    localparam int unsigned EVT_PIN = 1;
    // reset values
    localparam logic [7:0] RST_COUNT = 8'hff;
    localparam logic [6:0] RST_PRESCALE = 7'h7f;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    typedef enum logic [1:0] {MODE_EVENT, MODE_GATED, MODE_OUTPUT} mode_e;
endpackage

// ### logic/tick_divider.sv
// one-cycle enable pulse every DIV core clocks
// assumes a single clock domain
`timescale 1ns/100ps
module tick_divider #(
    parameter int unsigned DIV = 12
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    output logic tick
);
    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_q;
    wire wrap = (cnt_q == LAST);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            tick <= wrap;
        end
    end
endmodule

// ### logic/pin_sync.sv
// two-flop synchroniser with rising edge detect
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/100ps
module pin_sync (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic pinAsync,
    output logic level,
    output logic rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // only sync_q reads meta_q
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= pinAsync;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
endmodule

// ### dv/pin_partner.sv
// far side of the timer pin: a signal source that yields to the timer in output mode
// assumes one pin, no pull resistor; the source drives it whenever the timer does not
`timescale 1ns/100ps
module pin_partner (
    input wire logic driveLevel,
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinLevel
);
    // a driven timer wins; the source stands back so the wire never fights
    assign pinLevel = pinOe ? pinOut : driveLevel;
endmodule

// ### dv/down_counter_timer_test.sv
// self-checking bench for the down counter timer, wishbone master by tasks
// assumes the design files and pin_partner; CORE_DIV lowered to 3 to keep runs short
`timescale 1ns/100ps
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module down_counter_timer_test;
    logic ref_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, ack, pinLevel;
    logic pinOut, pinOe, irq, wakeReq, driveLevel = 0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h1;
    logic [31:0] dat = 32'h0, datOut;
    logic [7:0] q, r;
    int fails = 0, nChecks = 0;
    always #5 ref_clk = ~ref_clk;
    down_counter_timer #(.CORE_DIV(3)) down_counter_timer_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(datOut), .ack_o(ack), .timerPinIn(pinLevel),
        .timerPinOut(pinOut), .timerPinOe(pinOe), .irq(irq), .wakeReq(wakeReq));
    pin_partner pin_partner_i (.driveLevel(driveLevel), .pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinLevel));
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // holds the request until ack is seen; read data taken at that same edge
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
        output logic [7:0] v);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h000000, d};
        // no cycle budget here: a hang is left to the watchdog
        do
        begin
            @(posedge ref_clk);
        end
        while (ack !== 1'b1);
        v = datOut[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] v;
        wb(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] v);
        wb(1'b0, a, 8'h00, v);
    endtask
    task automatic pulse();
        driveLevel <= 1'b1; idle(4); driveLevel <= 1'b0; idle(4);
    endtask
    task automatic t_reset();
        rd(timer_pkg::ADR_PRESCALE, q); `CHK("prescale", 8'h7f, q)
        rd(timer_pkg::ADR_COUNT, q); `CHK("count", 8'hff, q)
        rd(timer_pkg::ADR_CONTROL, q); `CHK("control", 8'h00, q)
        rd(10'h000, q); `CHK("unmapped", 8'h00, q)
        `CHK("irq idle", 1'b0, irq)
    endtask
    task automatic t_flag();
        wr(timer_pkg::ADR_CONTROL, 8'h40);
        wr(timer_pkg::ADR_COUNT, 8'h00);
        rd(timer_pkg::ADR_CONTROL, q); `CHK("zero by write", 1'b1, q[7])
        `CHK("irq on", 1'b1, irq)
        `CHK("wake", 1'b1, wakeReq)
        wr(timer_pkg::ADR_CONTROL, 8'h00); idle(2);
        `CHK("irq off", 1'b0, irq)
        wr(timer_pkg::ADR_CONTROL, 8'h80);
        rd(timer_pkg::ADR_CONTROL, q); `CHK("zero by bit", 1'b1, q[7])
        `CHK("irq masked", 1'b0, irq)
        wr(timer_pkg::ADR_CONTROL, 8'h00);
    endtask
    task automatic t_output();
        int n;
        n = 0;
        wr(timer_pkg::ADR_COUNT, 8'h05);
        wr(timer_pkg::ADR_CONTROL, 8'h38);
        do
        begin
            rd(timer_pkg::ADR_CONTROL, q);
            n++;
        end
        while (q[7] !== 1'b1 && n < 60);
        `CHK("zero by count", 1'b1, q[7])
        rd(timer_pkg::ADR_EVT_STATUS, r); `CHK("evt zero", 1'b1, r[0])
        idle(2);
        `CHK("pin out", 1'b1, pinOut)
        `CHK("pin oe", 1'b1, pinOe)
        // flag cleared and data dropped: the pin must keep its old level
        wr(timer_pkg::ADR_CONTROL, 8'h20); idle(3);
        `CHK("pin held", 1'b1, pinOut)
        rd(timer_pkg::ADR_COUNT, q); idle(10); rd(timer_pkg::ADR_COUNT, r);
        `CHK("stopped", q, r)
        wr(timer_pkg::ADR_PRESCALE, 8'h55);
        rd(timer_pkg::ADR_PRESCALE, q); `CHK("prescale stopped", 8'h7f, q)
        wr(timer_pkg::ADR_CONTROL, 8'h08);
        wr(timer_pkg::ADR_PRESCALE, 8'hd5);
        rd(timer_pkg::ADR_PRESCALE, q); `CHK("prescale load", 8'h55, q)
    endtask
    task automatic t_event();
        wr(timer_pkg::ADR_CONTROL, 8'h00);
        wr(timer_pkg::ADR_COUNT, 8'h0a);
        wr(timer_pkg::ADR_CONTROL, 8'h09);
        repeat (4) pulse();
        rd(timer_pkg::ADR_COUNT, q); `CHK("event tap1", 8'h08, q)
        // stop presets the prescaler to 7f; divide by 4 then needs 8 edges for 2 steps
        wr(timer_pkg::ADR_CONTROL, 8'h00);
        wr(timer_pkg::ADR_CONTROL, 8'h0a);
        repeat (8) pulse();
        rd(timer_pkg::ADR_COUNT, q); `CHK("event tap2", 8'h06, q)
    endtask
    task automatic t_gated();
        wr(timer_pkg::ADR_CONTROL, 8'h00);
        wr(timer_pkg::ADR_COUNT, 8'h14);
        wr(timer_pkg::ADR_CONTROL, 8'h18); idle(30);
        rd(timer_pkg::ADR_COUNT, q); `CHK("gate low", 8'h14, q)
        driveLevel <= 1'b1; idle(30); driveLevel <= 1'b0; idle(5);
        rd(timer_pkg::ADR_COUNT, q); `CHK("gate high", 1'b1, q < 8'h14)
        idle(20); rd(timer_pkg::ADR_COUNT, r); `CHK("gate closed", q, r)
    endtask
    task automatic t_events_irq();
        wr(timer_pkg::ADR_EVT_CLEAR, 8'h03);
        rd(timer_pkg::ADR_EVT_STATUS, q); `CHK("evt clear", 8'h00, q)
        wr(timer_pkg::ADR_EVT_ENABLE, 8'h02);
        pulse();
        `CHK("evt irq", 1'b1, irq)
        rd(timer_pkg::ADR_EVT_STATUS, q); `CHK("evt pin", 1'b1, q[1])
        wr(timer_pkg::ADR_EVT_CLEAR, 8'h02); idle(2);
        `CHK("evt irq off", 1'b0, irq)
        wr(timer_pkg::ADR_EVT_ENABLE, 8'h00);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        idle(2);
        reset_n <= 1'b1;
        idle(1);
        t_reset();
        t_flag();
        t_output();
        t_event();
        t_gated();
        t_events_irq();
        give_verdict();
    end
    // all scenarios need a few hundred cycles; this leaves wide margin
    initial
    begin
        idle(20000);
        fails++;
        give_verdict();
    end
endmodule
